//--- rtl/scc_pkg.sv
// Package with register map, field positions, reset values and array geometry.
package scc_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] PLL_CONTROL_ADDR = 16'h300f;
  localparam logic [15:0] SYSTEM_RESET_CONTROL_ADDR = 16'h3012;
  localparam logic [15:0] CROP_X_START_HIGH_ADDR = 16'h3020;
  localparam logic [15:0] CROP_X_START_LOW_ADDR = 16'h3021;
  localparam logic [15:0] CROP_Y_START_HIGH_ADDR = 16'h3022;
  localparam logic [15:0] CROP_Y_START_LOW_ADDR = 16'h3023;
  localparam logic [15:0] CROP_WIDTH_HIGH_ADDR = 16'h3024;
  localparam logic [15:0] CROP_WIDTH_LOW_ADDR = 16'h3025;
  localparam logic [15:0] CROP_HEIGHT_HIGH_ADDR = 16'h3026;
  localparam logic [15:0] CROP_HEIGHT_LOW_ADDR = 16'h3027;
  localparam logic [15:0] IMAGE_SOURCE_SELECT_ADDR = 16'h306c;
  localparam logic [15:0] PATTERN_SELECT_ADDR = 16'h307b;
  localparam logic [15:0] READOUT_ORIENTATION_ADDR = 16'h307c;
  localparam logic [15:0] STRIPE_ENABLE_CONTROL_ADDR = 16'h307d;
  localparam logic [15:0] TEST_PATTERN_CONTROL_ADDR = 16'h3080;
  localparam logic [15:0] ARRAY_ORIENTATION_ADDR = 16'h3090;
  localparam logic [15:0] PAD_DIRECTION_LOW_ADDR = 16'h30b0;
  localparam logic [15:0] PAD_DIRECTION_HIGH_ADDR = 16'h30b1;
  localparam logic [15:0] PAD_STRENGTH_CONTROL_ADDR = 16'h30b2;
  localparam logic [15:0] READOUT_DELAY_CONTROL_ADDR = 16'h397c;
  localparam logic [15:0] SLEEP_CONTROL_ADDR = 16'h30f0;
  // ----------------------------------------------------------------
  // Register count and reset values
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 21;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PATTERN_SELECT_RESET = 8'h00;
  localparam logic [7:0] IMAGE_SOURCE_RESET = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PLL_BYPASS_BIT = 3;
  localparam int SOFT_RESET_BIT = 7;
  localparam int SLEEP_BIT = 0;
  localparam int MIRROR_BIT = 1;
  localparam int FLIP_BIT = 0;
  localparam int ARRAY_MIRROR_BIT = 3;
  localparam int DELAY_BIT = 1;
  localparam int TEST_ON_BIT = 7;
  localparam int STRIPE_EN_BIT = 7;
  localparam int SOURCE_BIT = 4;
  localparam int PIN_TWO_DIR_BIT = 7;
  localparam int PIN_ONE_DIR_BIT = 6;
  localparam int FSYNC_DIR_BIT = 5;
  localparam int FLASH_DIR_BIT = 4;
  localparam int PCLK_DIR_BIT = 3;
  localparam int LINE_VALID_DIR_BIT = 2;
  localparam logic [1:0] STRIPES_CODE = 2'b10;
  // ----------------------------------------------------------------
  // Array geometry and power-on reset length
  // ----------------------------------------------------------------
  localparam logic [15:0] ARRAY_COLS = 16'd2072;
  localparam logic [15:0] ARRAY_ROWS = 16'd1568;
  localparam logic [15:0] ACTIVE_COLS = 16'd2048;
  localparam logic [15:0] ACTIVE_ROWS = 16'd1536;
  localparam logic [15:0] ACTIVE_X0 = 16'd12;
  localparam logic [15:0] ACTIVE_Y0 = 16'd16;
  localparam logic [3:0] POR_CYCLES = 4'd15;
endpackage : scc_pkg

//--- rtl/scc_sync2.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/1ps
module scc_sync2 (
  input wire logic clk_in, // Core clock.
  input wire logic d_in,   // Asynchronous level.
  output logic q_out       // Synchronised level.
);
  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  always_comb begin
    nxt_meta = d_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_in) begin
    meta_ff <= nxt_meta;
    sync_ff <= nxt_sync;
  end

  assign q_out = sync_ff;
endmodule : scc_sync2

//--- rtl/scc_core.sv
// Sensor core control: registers, pads, clocks, resets, suspend and readout.
//
// How it works
// [RULE1] Pad drive strength is a two-bit code, 1x through 4x.
// [RULE2] Each of ten data pads has its own direction bit, 1 means output.
// [RULE3] General pin two direction follows bit 7 of the high direction register.
// [RULE4] General pin one direction follows bit 6 of the high direction register.
// [RULE5] Frame sync, flash, pixel clock and line valid pads each have a direction bit.
// [RULE6] PLL bypass bit makes the input clock drive the logic directly.
// [RULE7] Three derived clocks: core, serial link and image pipeline.
// [RULE8] Internal power-on reset clears the whole chip at power up; skipped if the counter powers up at its end value.
// [RULE9] Host should still pulse the reset pin after power up.
// [RULE10] Reset pin low returns every register to its default.
// [RULE11] Writing the soft reset bit resets the device.
// [RULE12] Standby pin high stops the clock and clears counters, keeps registers.
// [RULE13] Software sleep halts activity, keeps the clock and registers.
// [RULE14] Link low-power command powers down all but link low-speed and control bus.
// [RULE15] Read 2072 by 1568, output only the 2048 by 1536 active pixels.
// [RULE16] Mirror reverses horizontal order; array mirror is a separate enable.
// [RULE17] Readout delay bit shifts the readout sequence by one pixel.
// [RULE18] Flip reverses vertical order; red and blue lines adjust automatically.
// [RULE19] Cropping masks pixels outside the window without changing timing.
// [RULE20] Crop start, width and height are 16-bit, upper byte at lower address.
// [RULE21] Test-pattern bit switches the test pattern on or off.
// [RULE22] Stripe pattern needs select code 10 and stripe enable; source bit picks image.
`timescale 1ns/1ps
module scc_core #(
  parameter int AW = 16 // Register address width.
) (
  input wire logic CLK_IN,             // Input clock, 50 MHz.
  input wire logic RST_B_IN,           // Reset pin, active low, synchronous.
  input wire logic STANDBY_PIN_IN,     // Standby pin, active high, asynchronous.
  input wire logic LINK_ULPS_IN,       // Link low-power command level from link PHY.
  input wire logic REG_WR_IN,          // Register write strobe from control bus.
  input wire logic REG_RD_IN,          // Register read strobe from control bus.
  input wire logic [AW-1:0] REG_ADDR_IN, // Register address.
  input wire logic [7:0] REG_WDATA_IN, // Register write data.
  output logic [7:0] REG_RDATA_OUT,    // Register read data.
  output logic [1:0] PAD_STRENGTH_OUT, // Pad drive strength code.
  output logic [9:0] DATA_PAD_OE_B_OUT, // Data pad enables, low drives.
  output logic GENERAL_PIN_TWO_OE_B_OUT, // General pin two enable, low drives.
  output logic GENERAL_PIN_ONE_OE_B_OUT, // General pin one enable, low drives.
  output logic FRAME_SYNC_OE_B_OUT,    // Frame sync pad enable, low drives.
  output logic FLASH_OE_B_OUT,         // Flash trigger pad enable, low drives.
  output logic PIXEL_CLOCK_OE_B_OUT,   // Pixel clock pad enable, low drives.
  output logic LINE_VALID_PIN_OE_B_OUT, // Line valid pad enable, low drives.
  output logic PLL_BYPASS_OUT,         // PLL bypassed.
  output logic CORE_CLOCK_EN_OUT,      // Core clock enable.
  output logic SERIAL_LINK_CLOCK_EN_OUT, // Serial link clock enable.
  output logic PIPELINE_CLOCK_EN_OUT,  // Image pipeline clock enable.
  output logic CHIP_RESET_B_OUT,       // Chip reset, active low.
  output logic [15:0] COL_OUT,         // Array column being read.
  output logic [15:0] ROW_OUT,         // Array row being read.
  output logic PIXEL_VALID_OUT,        // Pixel is active and inside the crop window.
  output logic ROW_IS_RED_OUT,         // Current row carries red pixels.
  output logic READOUT_DELAY_OUT,      // Readout shifted by one pixel.
  output logic ARRAY_MIRROR_OUT,       // Array-level mirror enable.
  output logic STRIPES_OUT,            // Colour stripes pattern selected.
  output logic [7:0] STRIPE_LEVEL_OUT  // Stripe pattern value for current column.
);
  // ----------------------------------------------------------------
  // Synchronised pins and power-on reset
  // ----------------------------------------------------------------
  logic standby_s;
  logic ulps_s;
  logic [3:0] por_cnt_ff;
  logic [3:0] nxt_por_cnt;
  logic por_done;

  scc_sync2 u_standby_sync (
    .clk_in(CLK_IN),
    .d_in(STANDBY_PIN_IN),
    .q_out(standby_s)
  );

  // The low-power command comes from the link PHY domain, so it is synchronised too.
  scc_sync2 u_ulps_sync (
    .clk_in(CLK_IN),
    .d_in(LINK_ULPS_IN),
    .q_out(ulps_s)
  );

  // A pin reset restarts the count and clears any unknown power-up state of the counter.
  // Limitation: a counter that powers up at its end value skips the power-on hold.
  assign por_done = (por_cnt_ff == scc_pkg::POR_CYCLES);

  always_comb begin
    if (!RST_B_IN) begin
      nxt_por_cnt = 4'd0;
    end else begin
      nxt_por_cnt = por_done ? por_cnt_ff : por_cnt_ff + 4'd1; // [RULE8]
    end
  end

  always_ff @(posedge CLK_IN) begin
    por_cnt_ff <= nxt_por_cnt;
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs_ff [scc_pkg::NUM_REGS];
  logic [7:0] nxt_regs [scc_pkg::NUM_REGS];
  logic [AW-1:0] reg_addr [scc_pkg::NUM_REGS];
  logic [7:0] reg_rst [scc_pkg::NUM_REGS];
  logic soft_reset;
  logic reg_reset;

  always_comb begin
    reg_addr = '{scc_pkg::PLL_CONTROL_ADDR, scc_pkg::SYSTEM_RESET_CONTROL_ADDR,
                 scc_pkg::CROP_X_START_HIGH_ADDR, scc_pkg::CROP_X_START_LOW_ADDR,
                 scc_pkg::CROP_Y_START_HIGH_ADDR, scc_pkg::CROP_Y_START_LOW_ADDR,
                 scc_pkg::CROP_WIDTH_HIGH_ADDR, scc_pkg::CROP_WIDTH_LOW_ADDR,
                 scc_pkg::CROP_HEIGHT_HIGH_ADDR, scc_pkg::CROP_HEIGHT_LOW_ADDR,
                 scc_pkg::IMAGE_SOURCE_SELECT_ADDR, scc_pkg::PATTERN_SELECT_ADDR,
                 scc_pkg::READOUT_ORIENTATION_ADDR, scc_pkg::STRIPE_ENABLE_CONTROL_ADDR,
                 scc_pkg::TEST_PATTERN_CONTROL_ADDR, scc_pkg::ARRAY_ORIENTATION_ADDR,
                 scc_pkg::PAD_DIRECTION_LOW_ADDR, scc_pkg::PAD_DIRECTION_HIGH_ADDR,
                 scc_pkg::PAD_STRENGTH_CONTROL_ADDR, scc_pkg::READOUT_DELAY_CONTROL_ADDR,
                 scc_pkg::SLEEP_CONTROL_ADDR};
    for (int i = 0; i < scc_pkg::NUM_REGS; i++) begin
      reg_rst[i] = scc_pkg::REG_RESET;
    end
    reg_rst[10] = scc_pkg::IMAGE_SOURCE_RESET;
  end

  // The soft reset bit is self-clearing: it resets every register, itself included.
  assign soft_reset = regs_ff[1][scc_pkg::SOFT_RESET_BIT]; // [RULE11]
  assign reg_reset = !RST_B_IN || !por_done || soft_reset; // [RULE10] [RULE8]

  // Registers are written while in standby or sleep so the contents are kept.
  always_comb begin
    for (int i = 0; i < scc_pkg::NUM_REGS; i++) begin
      if (reg_reset) begin
        nxt_regs[i] = reg_rst[i]; // [RULE10]
      end else if (REG_WR_IN && REG_ADDR_IN == reg_addr[i]) begin
        nxt_regs[i] = REG_WDATA_IN;
      end else begin
        nxt_regs[i] = regs_ff[i]; // [RULE12] [RULE13]
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    regs_ff <= nxt_regs;
  end

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (!RST_B_IN) begin
      nxt_rdata = 8'h00;
    end else if (REG_RD_IN) begin
      nxt_rdata = 8'h00;
      for (int i = 0; i < scc_pkg::NUM_REGS; i++) begin
        if (REG_ADDR_IN == reg_addr[i]) begin
          nxt_rdata = regs_ff[i];
        end
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    rdata_ff <= nxt_rdata;
  end

  assign REG_RDATA_OUT = rdata_ff;

  // ----------------------------------------------------------------
  // Pads and clocks
  // ----------------------------------------------------------------
  logic [7:0] dir_hi;
  assign dir_hi = regs_ff[17];
  assign PAD_STRENGTH_OUT = regs_ff[18][1:0]; // [RULE1]
  assign DATA_PAD_OE_B_OUT = ~{dir_hi[1:0], regs_ff[16]}; // [RULE2]
  assign GENERAL_PIN_TWO_OE_B_OUT = ~dir_hi[scc_pkg::PIN_TWO_DIR_BIT]; // [RULE3]
  assign GENERAL_PIN_ONE_OE_B_OUT = ~dir_hi[scc_pkg::PIN_ONE_DIR_BIT]; // [RULE4]
  assign FRAME_SYNC_OE_B_OUT = ~dir_hi[scc_pkg::FSYNC_DIR_BIT]; // [RULE5]
  assign FLASH_OE_B_OUT = ~dir_hi[scc_pkg::FLASH_DIR_BIT]; // [RULE5]
  assign PIXEL_CLOCK_OE_B_OUT = ~dir_hi[scc_pkg::PCLK_DIR_BIT]; // [RULE5]
  assign LINE_VALID_PIN_OE_B_OUT = ~dir_hi[scc_pkg::LINE_VALID_DIR_BIT]; // [RULE5]
  assign PLL_BYPASS_OUT = regs_ff[0][scc_pkg::PLL_BYPASS_BIT]; // [RULE6]

  logic sleep;
  logic run;
  assign sleep = regs_ff[20][scc_pkg::SLEEP_BIT];
  // Standby halts every clock; sleep stops activity and the pipeline clock, the core clock keeps running.
  assign CORE_CLOCK_EN_OUT = !standby_s && !ulps_s; // [RULE7] [RULE12] [RULE13] [RULE14]
  assign SERIAL_LINK_CLOCK_EN_OUT = !standby_s && !ulps_s; // [RULE7] [RULE14]
  assign PIPELINE_CLOCK_EN_OUT = !standby_s && !sleep && !ulps_s; // [RULE7] [RULE14]
  assign CHIP_RESET_B_OUT = !reg_reset;
  assign run = !standby_s && !sleep && !ulps_s; // [RULE13]

  // ----------------------------------------------------------------
  // Readout counters
  // ----------------------------------------------------------------
  logic [15:0] col_ff;
  logic [15:0] row_ff;
  logic [15:0] nxt_col;
  logic [15:0] nxt_row;

  always_comb begin
    nxt_col = col_ff;
    nxt_row = row_ff;
    if (reg_reset || standby_s) begin
      nxt_col = 16'h0000; // [RULE12]
      nxt_row = 16'h0000;
    end else if (run) begin
      if (col_ff == scc_pkg::ARRAY_COLS - 16'd1) begin // [RULE15]
        nxt_col = 16'h0000;
        nxt_row = (row_ff == scc_pkg::ARRAY_ROWS - 16'd1) ? 16'h0000 : row_ff + 16'd1;
      end else begin
        nxt_col = col_ff + 16'd1;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    col_ff <= nxt_col;
    row_ff <= nxt_row;
  end

  // ----------------------------------------------------------------
  // Orientation, crop mask and pattern
  // ----------------------------------------------------------------
  logic mirror;
  logic flip;
  logic delay;
  logic [15:0] dcol;
  logic [15:0] ocol;
  logic [15:0] orow;
  logic [15:0] ax;
  logic [15:0] ay;
  logic active;
  logic in_crop;
  logic [15:0] crop_x_start;
  logic [15:0] crop_y_start;
  logic [15:0] crop_width;
  logic [15:0] crop_height;

  assign mirror = regs_ff[12][scc_pkg::MIRROR_BIT];
  assign flip = regs_ff[12][scc_pkg::FLIP_BIT];
  assign delay = regs_ff[19][scc_pkg::DELAY_BIT];
  assign crop_x_start = {regs_ff[2], regs_ff[3]}; // [RULE20]
  assign crop_y_start = {regs_ff[4], regs_ff[5]}; // [RULE20]
  assign crop_width = {regs_ff[6], regs_ff[7]}; // [RULE20]
  assign crop_height = {regs_ff[8], regs_ff[9]}; // [RULE20]

  // Delay shifts the sequence by one pixel to restore Bayer order under mirror.
  assign dcol = (delay && col_ff != 16'h0000) ? col_ff - 16'd1 : col_ff; // [RULE17]
  assign ocol = mirror ? scc_pkg::ARRAY_COLS - 16'd1 - dcol : dcol; // [RULE16]
  assign orow = flip ? scc_pkg::ARRAY_ROWS - 16'd1 - row_ff : row_ff; // [RULE18]
  assign ax = ocol - scc_pkg::ACTIVE_X0;
  assign ay = orow - scc_pkg::ACTIVE_Y0;
  assign active = ocol >= scc_pkg::ACTIVE_X0 && ax < scc_pkg::ACTIVE_COLS &&
                  orow >= scc_pkg::ACTIVE_Y0 && ay < scc_pkg::ACTIVE_ROWS; // [RULE15]
  // Crop only masks; counters run the same whatever the window is.
  assign in_crop = ax >= crop_x_start && ax - crop_x_start < crop_width &&
                   ay >= crop_y_start && ay - crop_y_start < crop_height; // [RULE19]

  logic stripes;
  assign stripes = regs_ff[14][scc_pkg::TEST_ON_BIT] && // [RULE21]
                   regs_ff[11][1:0] == scc_pkg::STRIPES_CODE &&
                   regs_ff[13][scc_pkg::STRIPE_EN_BIT] &&
                   !regs_ff[10][scc_pkg::SOURCE_BIT]; // [RULE22]

  logic valid_ff;
  logic red_ff;
  logic stripes_ff;
  logic [7:0] level_ff;
  logic nxt_valid;
  logic nxt_red;
  logic nxt_stripes;
  logic [7:0] nxt_level;

  always_comb begin
    nxt_valid = run && active && in_crop && !reg_reset;
    nxt_red = !orow[0]; // [RULE18]
    nxt_stripes = stripes;
    nxt_level = {ax[8], ax[8], ax[9], ax[9], ax[10], ax[10], 2'b00}; // [RULE22]
  end

  always_ff @(posedge CLK_IN) begin
    valid_ff <= nxt_valid;
    red_ff <= nxt_red;
    stripes_ff <= nxt_stripes;
    level_ff <= nxt_level;
  end

  assign COL_OUT = ocol;
  assign ROW_OUT = orow;
  assign PIXEL_VALID_OUT = valid_ff;
  assign ROW_IS_RED_OUT = red_ff;
  assign READOUT_DELAY_OUT = delay;
  assign ARRAY_MIRROR_OUT = regs_ff[15][scc_pkg::ARRAY_MIRROR_BIT]; // [RULE16]
  assign STRIPES_OUT = stripes_ff;
  assign STRIPE_LEVEL_OUT = level_ff;
endmodule : scc_core

//--- dv/scc_host_model.sv
// Host model that owns the register strobes of the control bus.
`timescale 1ns/1ps
module scc_host_model (
  input wire logic clk_in, // Core clock.
  input wire logic [7:0] rdata_in, // Read data.
  output logic wr_out, // Write strobe.
  output logic rd_out, // Read strobe.
  output logic [15:0] addr_out, // Address.
  output logic [7:0] wdata_out // Write data.
);
  initial begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 16'hffff;
    wdata_out = 8'h00;
  end
  // Released lines show the inverse so a stale value is never mistaken for a held one.
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    d = rdata_in;
  endtask : rd_reg
endmodule : scc_host_model

//--- dv/scc_assertions.sv
// Checker for the register-driven outputs of the sensor core control block.
`timescale 1ns/1ps
module scc_assertions #(
  parameter int AW = 16 // Register address width.
) (
  input wire logic CLK_IN, // Clock.
  input wire logic RST_B_IN, // Reset, active low.
  input wire logic STANDBY_PIN_IN, // Standby pin.
  input wire logic REG_WR_IN, // Write strobe.
  input wire logic [AW-1:0] REG_ADDR_IN, // Address.
  input wire logic [7:0] REG_WDATA_IN, // Write data.
  input wire logic [1:0] PAD_STRENGTH_OUT, // Strength code.
  input wire logic [9:0] DATA_PAD_OE_B_OUT, // Data pad enables.
  input wire logic GENERAL_PIN_TWO_OE_B_OUT, // Pin two enable.
  input wire logic GENERAL_PIN_ONE_OE_B_OUT, // Pin one enable.
  input wire logic PLL_BYPASS_OUT, // Bypass.
  input wire logic CORE_CLOCK_EN_OUT, // Core clock enable.
  input wire logic CHIP_RESET_B_OUT, // Chip reset.
  input wire logic ARRAY_MIRROR_OUT // Array mirror.
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);
  wire logic w_str = REG_WR_IN && REG_ADDR_IN == 16'h30b2;
  wire logic w_lo = REG_WR_IN && REG_ADDR_IN == 16'h30b0;
  wire logic w_hi = REG_WR_IN && REG_ADDR_IN == 16'h30b1;
  wire logic w_pll = REG_WR_IN && REG_ADDR_IN == 16'h300f;
  wire logic w_arr = REG_WR_IN && REG_ADDR_IN == 16'h3090;
  wire logic w_rst = REG_WR_IN && REG_ADDR_IN == 16'h3012 && REG_WDATA_IN[7];
  a_strength_follows: assert property (
    w_str |=> {6'h00, PAD_STRENGTH_OUT} == ($past(REG_WDATA_IN) & 8'h03))
    else $error("pad strength differs from written code");
  a_data_dir_low: assert property (
    w_lo |=> DATA_PAD_OE_B_OUT[7:0] == ~$past(REG_WDATA_IN))
    else $error("data pad direction differs from written bits");
  a_pin_two_dir: assert property (
    w_hi |=> {GENERAL_PIN_TWO_OE_B_OUT, 7'h00} == (~$past(REG_WDATA_IN) & 8'h80))
    else $error("pin two direction wrong");
  a_pin_one_dir: assert property (
    w_hi |=> {1'b0, GENERAL_PIN_ONE_OE_B_OUT, 6'h00} == (~$past(REG_WDATA_IN) & 8'h40))
    else $error("pin one direction wrong");
  a_pll_bypass_set: assert property (
    w_pll |=> {4'h0, PLL_BYPASS_OUT, 3'h0} == ($past(REG_WDATA_IN) & 8'h08))
    else $error("pll bypass differs from written bit");
  a_array_mirror_set: assert property (
    w_arr |=> {4'h0, ARRAY_MIRROR_OUT, 3'h0} == ($past(REG_WDATA_IN) & 8'h08))
    else $error("array mirror differs from written bit");
  a_pin_reset_defaults: assert property (
    $rose(RST_B_IN) |-> PAD_STRENGTH_OUT == 2'b00 && DATA_PAD_OE_B_OUT == 10'h3ff
      && !PLL_BYPASS_OUT)
    else $error("outputs not at defaults after reset");
  a_standby_stops_clock: assert property (
    STANDBY_PIN_IN [*4] |-> !CORE_CLOCK_EN_OUT)
    else $error("core clock still enabled in standby");
  a_soft_reset_clears: assert property (
    w_rst |-> ##[1:2] !CHIP_RESET_B_OUT ##[0:2] PAD_STRENGTH_OUT == 2'b00)
    else $error("soft reset did not reset the chip");
  c_strength: cover property (w_str);
  c_soft_reset: cover property (w_rst);
  c_standby: cover property (STANDBY_PIN_IN ##4 !CORE_CLOCK_EN_OUT);
endmodule : scc_assertions

//--- dv/tb_top.sv
// Self-checking testbench for the sensor core control block.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic clk_in;
  logic rst_b_in;
  logic standby_in;
  logic ulps_in;
  logic wr;
  logic rd;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [1:0] strength;
  logic [9:0] data_oe_b;
  logic [5:0] pin_oe_b;
  logic pll_byp, core_en, link_en, pipe_en, delay_o, amirror, stripes, pix_valid, red;
  logic [15:0] col, row;
  logic [7:0] rv;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  localparam logic [15:0] ADDRS [20] = '{16'h300f, 16'h3012, 16'h3020, 16'h3021, 16'h3022,
    16'h3023, 16'h3024, 16'h3025, 16'h3026, 16'h3027, 16'h306c, 16'h307b, 16'h307c,
    16'h307d, 16'h3080, 16'h3090, 16'h30b0, 16'h30b1, 16'h30b2, 16'h397c};
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  scc_host_model host (.clk_in(clk_in), .rdata_in(rdata), .wr_out(wr), .rd_out(rd),
    .addr_out(addr), .wdata_out(wdata));
  scc_core #(.AW(16)) DUT (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .STANDBY_PIN_IN(standby_in),
    .LINK_ULPS_IN(ulps_in), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .PAD_STRENGTH_OUT(strength),
    .DATA_PAD_OE_B_OUT(data_oe_b), .GENERAL_PIN_TWO_OE_B_OUT(pin_oe_b[5]),
    .GENERAL_PIN_ONE_OE_B_OUT(pin_oe_b[4]), .FRAME_SYNC_OE_B_OUT(pin_oe_b[3]),
    .FLASH_OE_B_OUT(pin_oe_b[2]), .PIXEL_CLOCK_OE_B_OUT(pin_oe_b[1]),
    .LINE_VALID_PIN_OE_B_OUT(pin_oe_b[0]), .PLL_BYPASS_OUT(pll_byp),
    .CORE_CLOCK_EN_OUT(core_en), .SERIAL_LINK_CLOCK_EN_OUT(link_en),
    .PIPELINE_CLOCK_EN_OUT(pipe_en), .CHIP_RESET_B_OUT(), .COL_OUT(col), .ROW_OUT(row),
    .PIXEL_VALID_OUT(pix_valid), .ROW_IS_RED_OUT(red), .READOUT_DELAY_OUT(delay_o),
    .ARRAY_MIRROR_OUT(amirror), .STRIPES_OUT(stripes), .STRIPE_LEVEL_OUT());
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic test_done();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic check_defaults();
    foreach (ADDRS[i]) begin
      host.rd_reg(ADDRS[i], rv);
      `CHK(rv, (ADDRS[i] == 16'h306c) ? 8'h10 : 8'h00)
    end
  endtask : check_defaults
  // Bit 7 stays clear so the system register write does not start a soft reset.
  task automatic t_rw_all();
    foreach (ADDRS[i]) host.wr_reg(ADDRS[i], ADDRS[i][7:0] ^ 8'h25);
    foreach (ADDRS[i]) begin
      host.rd_reg(ADDRS[i], rv);
      `CHK(rv, ADDRS[i][7:0] ^ 8'h25)
    end
    host.wr_reg(16'h3000, 8'hff);
    host.rd_reg(16'h3000, rv);
    `CHK(rv, 8'h00)
  endtask : t_rw_all
  task automatic t_strength();
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(16'h30b2, 8'(c));
      `CHK(strength, 2'(c))
    end
  endtask : t_strength
  task automatic t_pads();
    logic [7:0] v;
    for (int k = 0; k < 2; k++) begin
      v = (k == 0) ? 8'haa : 8'h55;
      host.wr_reg(16'h30b0, ~v);
      host.wr_reg(16'h30b1, v);
      `CHK(data_oe_b, ~{v[1:0], ~v})
      `CHK(pin_oe_b[5:4], ~v[7:6])
      `CHK(pin_oe_b[3:0], ~v[5:2])
    end
  endtask : t_pads
  task automatic t_clock_ctl();
    host.wr_reg(16'h300f, 8'h08);
    host.wr_reg(16'h3090, 8'h08);
    host.wr_reg(16'h397c, 8'h02);
    `CHK({pll_byp, amirror, delay_o}, 3'b111)
    host.wr_reg(16'h300f, 8'hf7);
    host.wr_reg(16'h3090, 8'hf7);
    host.wr_reg(16'h397c, 8'hfd);
    `CHK({pll_byp, amirror, delay_o}, 3'b000)
  endtask : t_clock_ctl
  task automatic t_power();
    @(posedge clk_in);
    standby_in <= 1'b1;
    repeat (6) tick();
    `CHK({core_en, link_en, pipe_en, col}, {3'b000, 16'h0000})
    @(posedge clk_in);
    standby_in <= 1'b0;
    repeat (6) tick();
    `CHK({core_en, link_en, pipe_en}, 3'b111)
    host.rd_reg(16'h30b2, rv);
    `CHK(rv, 8'h03)
    host.wr_reg(16'h30f0, 8'h01);
    tick();
    `CHK({core_en, link_en, pipe_en}, 3'b110)
    host.wr_reg(16'h30f0, 8'h00);
    @(posedge clk_in);
    ulps_in <= 1'b1;
    repeat (6) tick();
    host.wr_reg(16'h30b2, 8'h01);
    host.rd_reg(16'h30b2, rv);
    `CHK({core_en, link_en, rv}, {2'b00, 8'h01})
    @(posedge clk_in);
    ulps_in <= 1'b0;
    repeat (6) tick();
  endtask : t_power
  task automatic t_stripes();
    host.wr_reg(16'h3080, 8'h80);
    host.wr_reg(16'h307b, 8'h02);
    host.wr_reg(16'h307d, 8'h80);
    host.wr_reg(16'h306c, 8'h00);
    tick();
    `CHK(stripes, 1'b1)
    host.wr_reg(16'h306c, 8'h10);
    tick();
    `CHK(stripes, 1'b0)
    host.wr_reg(16'h306c, 8'h00);
    host.wr_reg(16'h3080, 8'h00);
    tick();
    `CHK(stripes, 1'b0)
  endtask : t_stripes
  // Mirror, flip and delay on; crop x start 16 width 16, y start 0 height 4096.
  // Of the counted counter rows 15 and 16, only row 16 is both active and inside the window under flip.
  task automatic t_readout();
    logic [15:0] n;
    host.wr_reg(16'h307c, 8'h03);
    host.wr_reg(16'h397c, 8'h02);
    foreach (ADDRS[i]) begin
      if (ADDRS[i][15:4] == 12'h302) begin
        host.wr_reg(ADDRS[i], (ADDRS[i][2:0] inside {3'd1, 3'd5, 3'd6}) ? 8'h10 : 8'h00);
      end
    end
    @(posedge clk_in);
    standby_in <= 1'b1;
    repeat (4) tick();
    @(posedge clk_in);
    standby_in <= 1'b0;
    repeat (2) tick();
    `CHK({col, row, red}, {16'd2071, 16'd1567, 1'b0})
    tick();
    `CHK(col, 16'd2071)
    repeat (15 * 2072 - 1) tick();
    n = 16'h0000;
    repeat (2 * 2072) begin
      tick();
      n = n + {15'h0000, pix_valid};
    end
    `CHK(n, 16'h0010)
  endtask : t_readout
  task automatic t_resets();
    host.wr_reg(16'h30b2, 8'h02);
    host.wr_reg(16'h3012, 8'h80);
    repeat (4) tick();
    check_defaults();
    host.wr_reg(16'h30b2, 8'h02);
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    check_defaults();
  endtask : t_resets
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 45000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rst_b_in = 1'b0;
    standby_in = 1'b0;
    ulps_in = 1'b0;
    repeat (16) @(posedge clk_in);
    rst_b_in <= 1'b1;
    check_defaults();
    t_rw_all();
    t_strength();
    t_pads();
    t_clock_ctl();
    t_power();
    t_stripes();
    t_readout();
    t_resets();
    test_done();
  end
endmodule : tb_top
bind scc_core scc_assertions #(.AW(AW)) u_chk (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
  .STANDBY_PIN_IN(STANDBY_PIN_IN), .REG_WR_IN(REG_WR_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .PAD_STRENGTH_OUT(PAD_STRENGTH_OUT),
  .DATA_PAD_OE_B_OUT(DATA_PAD_OE_B_OUT), .GENERAL_PIN_TWO_OE_B_OUT(GENERAL_PIN_TWO_OE_B_OUT),
  .GENERAL_PIN_ONE_OE_B_OUT(GENERAL_PIN_ONE_OE_B_OUT), .PLL_BYPASS_OUT(PLL_BYPASS_OUT),
  .CORE_CLOCK_EN_OUT(CORE_CLOCK_EN_OUT), .CHIP_RESET_B_OUT(CHIP_RESET_B_OUT),
  .ARRAY_MIRROR_OUT(ARRAY_MIRROR_OUT));
